// *** logic/eau_pkg.sv ***
// package of constants and carriers for the effective address unit
// Function
// - address comes from instruction bits 5..15, bit 0 being msb
// - bit 5 is indirect; bits 6..7 pick absolute, pc, index a, index b
// - non-absolute modes sign-extend the 8-bit displacement, -128..+127
// - absolute mode zero-extends displacement, reaching page zero only
// - pc relative address is pc plus signed displacement
// - first indexed mode adds signed displacement to index_accum_a
// - second indexed mode adds signed displacement to index_accum_b
// - indirect clear uses address directly, set fetches pointer
// - all address sums wrap to 15 bits
// - pointer bit 0 zero ends chain, one fetches bits 1..15 again
// - counter cleared at start, plus two per fetch, three for auto locations
// - counter above 17 before resolution halts the processor
// - octal 020..027 pointer increments, writes back, uses new value
// - octal 030..037 pointer decrements, writes back, uses new value
// - auto locations decide continuation on bit 0 before update
// - addresses and pc are 15 bits, words and accumulators 16 bits
package eau_pkg;

  // ---------------------------------------------------------------
  // widths and field positions (bit 0 is msb, so lsb index = 15 - n)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int WORD_W = 16;
  localparam int DISP_W = 8;
  localparam int IND_POS = 10;    // instruction bit 5
  localparam int MODE_HI = 9;     // instruction bit 6
  localparam int MODE_LO = 8;     // instruction bit 7
  localparam int PTR_FLAG_POS = 15; // word bit 0

  // ---------------------------------------------------------------
  // modes, ranges and counter figures
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_ABS = 2'h0;
  localparam logic [1:0] MODE_PC = 2'h1;
  localparam logic [1:0] MODE_IDXA = 2'h2;
  localparam logic [1:0] MODE_IDXB = 2'h3;
  localparam logic [ADDR_W-1:0] AUTO_INC_LO = 15'h0010; // octal 020
  localparam logic [ADDR_W-1:0] AUTO_INC_HI = 15'h0017; // octal 027
  localparam logic [ADDR_W-1:0] AUTO_DEC_LO = 15'h0018; // octal 030
  localparam logic [ADDR_W-1:0] AUTO_DEC_HI = 15'h001F; // octal 037
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_STEP = 5'h02;
  localparam logic [CNT_W-1:0] CNT_STEP_AUTO = 5'h03;
  localparam logic [CNT_W-1:0] CNT_LIMIT = 5'h11;  // 17
  localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;

  typedef enum {EauIdle, EauRead, EauWait, EauWrite, EauHalt} eau_state_e;

  // request from the sequencer
  typedef struct packed {
    logic [WORD_W-1:0] instr;
    logic [ADDR_W-1:0] pc;
    logic [WORD_W-1:0] accA;
    logic [WORD_W-1:0] accB;
  } eau_req_s;

  // memory cycle issued by the unit
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } eau_mem_s;

endpackage

// *** logic/eau_addr_calc.sv ***
// combinational address former for one instruction word
`timescale 1ns/1ps
`default_nettype none
module eau_addr_calc (
  // instruction context
  input wire eau_pkg::eau_req_s req,
  // formed address
  output logic [eau_pkg::ADDR_W-1:0] addr,
  output logic indirect
);
  import eau_pkg::*;

  // sign or zero extend the displacement to address width
  function automatic logic [ADDR_W-1:0] extDisp(input logic [DISP_W-1:0] d, input logic sgn);
    extDisp = sgn ? {{(ADDR_W-DISP_W){d[DISP_W-1]}}, d} : {{(ADDR_W-DISP_W){1'b0}}, d};
  endfunction

  logic [1:0] mode;
  logic [ADDR_W-1:0] disp;
  assign mode = req.instr[MODE_HI:MODE_LO];
  assign indirect = req.instr[IND_POS];
  assign disp = extDisp(req.instr[DISP_W-1:0], mode != MODE_ABS);

  // sums keep only 15 bits, the carry simply falls off
  always_comb begin
    case (mode)
      MODE_ABS: addr = disp;
      MODE_PC: addr = req.pc + disp;
      MODE_IDXA: addr = req.accA[ADDR_W-1:0] + disp;
      MODE_IDXB: addr = req.accB[ADDR_W-1:0] + disp;
      default: addr = disp;
    endcase
  end
endmodule // eau_addr_calc
`default_nettype wire

// *** logic/eau_auto_adj.sv ***
// adjusts a fetched pointer word for auto increment and decrement locations
`timescale 1ns/1ps
`default_nettype none
module eau_auto_adj (
  // fetched word and its location
  input wire logic [eau_pkg::ADDR_W-1:0] loc,
  input wire logic [eau_pkg::WORD_W-1:0] word,
  // adjusted result
  output logic [eau_pkg::WORD_W-1:0] adjWord,
  output logic isAuto
);
  import eau_pkg::*;

  logic isInc;
  logic isDec;
  assign isInc = (loc >= AUTO_INC_LO) && (loc <= AUTO_INC_HI);
  assign isDec = (loc >= AUTO_DEC_LO) && (loc <= AUTO_DEC_HI);
  assign isAuto = isInc | isDec;

  // full 16-bit arithmetic, bit 0 included
  always_comb begin
    if (isInc) begin
      adjWord = word + WORD_ONE;
    end else if (isDec) begin
      adjWord = word - WORD_ONE;
    end else begin
      adjWord = word;
    end
  end
endmodule // eau_auto_adj
`default_nettype wire

// *** logic/eau_unit.sv ***
// effective address unit: mode decode, indirection chain, auto update, runaway halt
`timescale 1ns/1ps
`default_nettype none
module eau_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request from the sequencer
  input wire logic start,
  input wire eau_pkg::eau_req_s req,
  input wire logic contCmd,
  // result
  output logic done,
  output logic [eau_pkg::ADDR_W-1:0] effAddr,
  output logic halted,
  output logic busy,
  // memory port
  output var eau_pkg::eau_mem_s mem,
  input wire logic memAck,
  input wire logic [eau_pkg::WORD_W-1:0] memRdata
);
  import eau_pkg::*;

  // ---------------------------------------------------------------
  // datapath pieces
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] calcAddr;
  logic calcInd;
  logic [WORD_W-1:0] adjWord;
  logic isAuto;
  eau_state_e state_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [WORD_W-1:0] wb_reg;
  logic [ADDR_W-1:0] effAddr_reg;
  logic done_reg;
  logic rdWord0;

  eau_addr_calc calc (
    .req(req),
    .addr(calcAddr),
    .indirect(calcInd)
  );

  eau_auto_adj adj (
    .loc(ptr_reg),
    .word(memRdata),
    .adjWord(adjWord),
    .isAuto(isAuto)
  );

  // all-ones from absent memory is just another word, no special case
  assign rdWord0 = memRdata[PTR_FLAG_POS]; // pre-update flag decides
  assign cnt_next = cnt_reg + (isAuto ? CNT_STEP_AUTO : CNT_STEP);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // read is held until acknowledged; write-back follows an auto location
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= EauIdle;
    end else begin
      case (state_reg)
        EauIdle: begin
          if (start && calcInd) begin
            state_reg <= EauRead;
          end
        end
        EauRead: begin
          if (memAck) begin
            if (cnt_next > CNT_LIMIT) begin
              state_reg <= EauHalt;
            end else if (isAuto) begin
              state_reg <= EauWrite;
            end else if (!rdWord0) begin
              state_reg <= EauIdle;
            end
          end
        end
        EauWrite: begin
          if (memAck) begin
            state_reg <= wb_reg[PTR_FLAG_POS] ? EauRead : EauIdle;
          end
        end
        EauHalt: begin
          if (contCmd) begin
            state_reg <= EauIdle;
          end
        end
        default: state_reg <= EauIdle;
      endcase
    end
  end

  // pointer, counter and write-back word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_reg <= '0;
      cnt_reg <= '0;
      wb_reg <= '0;
    end else if (state_reg == EauIdle && start) begin
      ptr_reg <= calcAddr;
      cnt_reg <= '0;
    end else if (state_reg == EauRead && memAck) begin
      cnt_reg <= cnt_next;
      wb_reg <= {rdWord0, adjWord[ADDR_W-1:0]};
      if (!isAuto) begin
        ptr_reg <= memRdata[ADDR_W-1:0];
      end
    end else if (state_reg == EauWrite && memAck) begin
      ptr_reg <= wb_reg[ADDR_W-1:0]; // new value used as pointer
    end else if (state_reg == EauHalt && contCmd) begin
      cnt_reg <= '0; // an over-limit count must not outlive the halt
    end
  end

  // full updated word kept separately for the memory write
  logic [WORD_W-1:0] wdata_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdata_reg <= '0;
    end else if (state_reg == EauRead && memAck) begin
      wdata_reg <= adjWord;
    end
  end

  // result register and its completion pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      effAddr_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (state_reg == EauIdle && start && !calcInd) begin
        effAddr_reg <= calcAddr;
        done_reg <= 1'b1;
      end else if (state_reg == EauRead && memAck && !isAuto && !rdWord0
                   && !(cnt_next > CNT_LIMIT)) begin
        effAddr_reg <= memRdata[ADDR_W-1:0];
        done_reg <= 1'b1;
      end else if (state_reg == EauWrite && memAck && !wb_reg[PTR_FLAG_POS]) begin
        effAddr_reg <= wb_reg[ADDR_W-1:0];
        done_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign done = done_reg;
  assign effAddr = effAddr_reg;
  assign halted = (state_reg == EauHalt);
  assign busy = (state_reg != EauIdle);
  // halted state issues nothing on the memory port
  assign mem.rd = (state_reg == EauRead);
  assign mem.wr = (state_reg == EauWrite);
  assign mem.addr = ptr_reg;
  assign mem.wdata = wdata_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence directReq;
    state_reg == EauIdle && start && !calcInd;
  endsequence

  sequence indReq;
    state_reg == EauIdle && start && calcInd;
  endsequence

  direct_done_a: assert property (directReq |=> done && effAddr == $past(calcAddr))
    else $error("direct address not delivered next cycle");
  ind_read_a: assert property (indReq |=> mem.rd && mem.addr == $past(calcAddr) && cnt_reg == '0)
    else $error("indirect reference did not start a clean read");
  halt_quiet_a: assert property (halted && !contCmd |=> halted && !mem.rd && !mem.wr)
    else $error("halted unit left halt or issued memory cycle");
  cnt_limit_a: assert property (cnt_reg > CNT_LIMIT |-> halted)
    else $error("counter above limit without halt");
  cnt_step_a: assert property (mem.rd && memAck && !isAuto |=> cnt_reg == $past(cnt_reg) + CNT_STEP)
    else $error("plain pointer fetch counter step wrong");
  auto_wb_a: assert property (mem.rd && memAck && isAuto && cnt_next <= CNT_LIMIT
      |=> mem.wr && mem.wdata == $past(adjWord))
    else $error("auto location not written back");
  chain_next_a: assert property (mem.rd && memAck && !isAuto && rdWord0 && cnt_next <= CNT_LIMIT
      |=> mem.rd && mem.addr == $past(memRdata[ADDR_W-1:0]))
    else $error("chain did not follow pointer");
  runaway_a: assert property (mem.rd && memAck && cnt_next > CNT_LIMIT |=> halted)
    else $error("runaway chain did not halt");
  resolve_a: assert property (mem.rd && memAck && !isAuto && !rdWord0 && cnt_next <= CNT_LIMIT
      |=> done && effAddr == $past(memRdata[ADDR_W-1:0]))
    else $error("resolved pointer not delivered");
endmodule // eau_unit
`default_nettype wire

// *** tb/eau_mem_model.sv ***
// behavioural memory on the far side of the unit's memory port
`timescale 1ns/1ps
`default_nettype none
module eau_mem_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // memory port and pacing
  input wire eau_pkg::eau_mem_s mem,
  input wire logic slow,
  output logic memAck,
  output logic [eau_pkg::WORD_W-1:0] memRdata
);
  import eau_pkg::*;
  logic [WORD_W-1:0] store [logic [ADDR_W-1:0]];
  int waitCnt = 0;
  // answers at once or after three waits; the data bus toggles when idle
  // so that a stale word never looks like a valid answer
  always @(posedge clk_sys) begin
    if (rst) begin
      memAck <= 1'b0;
      memRdata <= 16'hA5A5;
      waitCnt <= 0;
    end else if (memAck || !(mem.rd || mem.wr) || waitCnt > 0) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (!memAck && (mem.rd || mem.wr)) begin
        waitCnt <= waitCnt - 1;
      end
    end else begin
      memAck <= 1'b1;
      waitCnt <= slow ? 3 : 0;
      if (mem.wr) begin
        store[mem.addr] = mem.wdata;
      end
      memRdata <= store.exists(mem.addr) ? store[mem.addr] : 16'hFFFF;
    end
  end
endmodule // eau_mem_model
`default_nettype wire

// *** tb/effective_address_unit_test.sv ***
// self-checking bench for the effective address unit
`timescale 1ns/1ps
`default_nettype none
module effective_address_unit_test;
  import eau_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic contCmd = 1'b0;
  logic slow = 1'b0;
  eau_req_s req = '0;
  logic done, halted, busy, memAck;
  logic [ADDR_W-1:0] effAddr;
  logic [WORD_W-1:0] memRdata;
  eau_mem_s mem;
  logic [WORD_W-1:0] refMem [logic [ADDR_W-1:0]];
  int bad_count = 0;
  int checked = 0;
  int unsigned seed = 18393;

  // ---------------------------------------------------------------
  // design, memory and clock
  // ---------------------------------------------------------------
  eau_unit i_dut (.clk_sys(clk_sys), .rst(rst), .start(start), .req(req), .contCmd(contCmd),
    .done(done), .effAddr(effAddr), .halted(halted), .busy(busy), .mem(mem),
    .memAck(memAck), .memRdata(memRdata));
  eau_mem_model i_mem (.clk_sys(clk_sys), .rst(rst), .mem(mem), .slow(slow),
    .memAck(memAck), .memRdata(memRdata));
  initial forever #12.5 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // helpers and reference model
  // ---------------------------------------------------------------
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic poke(input logic [14:0] a, input logic [15:0] w);
    refMem[a] = w;
    i_mem.store[a] = w;
  endtask
  // result bit 15 set means the chain ran away
  function automatic logic [15:0] model_ea(input eau_req_s r);
    logic [14:0] a;
    logic [14:0] d;
    logic [15:0] w;
    logic [15:0] nw;
    int cnt;
    d = r.instr[9:8] == 2'h0 ? {7'h00, r.instr[7:0]} : {{7{r.instr[7]}}, r.instr[7:0]};
    case (r.instr[9:8])
      2'h0: a = d;
      2'h1: a = r.pc + d;
      2'h2: a = r.accA[14:0] + d;
      default: a = r.accB[14:0] + d;
    endcase
    if (!r.instr[10]) return {1'b0, a};
    cnt = 0;
    forever begin
      w = refMem.exists(a) ? refMem[a] : 16'hFFFF;
      nw = w;
      if (a >= 15'h10 && a <= 15'h17) nw = w + 16'h1;
      if (a >= 15'h18 && a <= 15'h1F) nw = w - 16'h1;
      cnt += (a >= 15'h10 && a <= 15'h1F) ? 3 : 2;
      if (cnt > 17) return 16'h8000;
      if (nw != w) refMem[a] = nw;
      a = nw[14:0];
      if (!w[15]) return {1'b0, a};
    end
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one request through to its result, then the halt and write-back checks
  task automatic run(input eau_req_s r);
    logic [15:0] exp;
    int n;
    exp = model_ea(r);
    @(posedge clk_sys);
    start <= 1'b1;
    req <= r;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    for (n = 0; n < 400 && done !== 1'b1 && halted !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (n == 400) begin
      check(16'h0, 16'h1, "no result");
      close_out();
    end
    check({15'h0, halted}, {15'h0, exp[15]}, "halt state");
    if (halted === 1'b1) begin
      repeat (4) begin
        @(posedge clk_sys);
        #1;
        check({14'h0, mem.rd, mem.wr}, 16'h0, "memory cycle while halted");
      end
      @(posedge clk_sys);
      contCmd <= 1'b1;
      @(posedge clk_sys);
      contCmd <= 1'b0;
      #1;
      check({15'h0, busy}, 16'h0, "busy after continue");
    end else begin
      check({1'b0, effAddr}, exp, "effective address");
    end
    for (n = 16; n < 32; n++) begin
      check(i_mem.store[n], refMem[n], "auto location");
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence: directed corners, then random traffic
  // ---------------------------------------------------------------
  initial begin
    eau_req_s r;
    int unsigned v;
    int i;
    logic [15:0] dIns [7] = '{16'h0410, 16'h0418, 16'h010A, 16'h0280, 16'h037F, 16'h0500,
      16'h0440};
    for (i = 0; i < 256; i++) begin
      v = xs();
      poke(15'(i), {v[1:0] == 2'h0, 7'h00, v[15:8]});
    end
    poke(15'h10, 16'hFFFF);
    poke(15'h00, 16'h0123);
    poke(15'h18, 16'h0000);
    for (i = 0; i < 8; i++) begin
      poke(15'(15'h40 + i), i < 7 ? 16'(16'h8041 + i) : 16'h0ABC);
    end
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check({12'h0, mem.rd, mem.wr, busy, halted}, 16'h0, "reset state");
    check({done, effAddr}, 16'h0, "reset result");
    r = '{instr: 16'h0, pc: 15'h7FFC, accA: 16'h0005, accB: 16'hFFFF};
    // auto wrap, auto borrow, pc wrap, -128, +127, absent chain, eight levels
    foreach (dIns[k]) begin
      r.instr = dIns[k];
      run(r);
    end
    poke(15'h47, 16'h8048);
    r.instr = 16'h0440;
    run(r);
    // the same runaway again, this time left by a reset instead of continue
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (60) @(posedge clk_sys);
    #1;
    check({15'h0, halted}, 16'h0001, "runaway before reset");
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check({12'h0, mem.rd, mem.wr, busy, halted}, 16'h0, "halt left by reset");
    check({done, effAddr}, 16'h0, "result after reset");
    for (i = 0; i < 80; i++) begin
      v = xs();
      slow <= v[31];
      r = '{instr: v[15:0], pc: {7'h00, v[23:16]}, accA: 16'(xs()), accB: {8'h00, v[31:24]}};
      run(r);
    end
    close_out();
  end
endmodule // effective_address_unit_test
`default_nettype wire
